// ===== shared/bcr_pkg.sv
// board control register constants, field positions and carrier types
package brd_pkg;

   // ---------------------------------------------------------------
   // address map and access
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W              = 8;
   localparam logic [7:0]  BOARD_CONTROL_OFFSET = 8'h00;
   localparam int unsigned WORD_W              = 32;

   // ---------------------------------------------------------------
   // field positions inside the board control word
   // ---------------------------------------------------------------
   localparam int unsigned POS_MODE      = 0;
   localparam int unsigned POS_RANGE     = 2;
   localparam int unsigned POS_CODING    = 4;
   localparam int unsigned POS_INITIATOR = 5;
   localparam int unsigned POS_ALIGN     = 6;
   localparam int unsigned POS_CAL       = 7;
   localparam int unsigned POS_EVSEL     = 8;
   localparam int unsigned POS_IRQ       = 11;
   localparam int unsigned POS_CALOK     = 12;
   localparam int unsigned POS_SETTLED   = 13;
   localparam int unsigned POS_FILL      = 14;
   localparam int unsigned POS_INIT      = 15;
   localparam int unsigned POS_FREE      = 16;
   localparam int unsigned POS_FLUSH     = 17;
   localparam int unsigned POS_GENA      = 18;
   localparam int unsigned POS_LOWF      = 19;
   localparam int unsigned POS_TTL       = 20;
   localparam int unsigned POS_TRIG      = 21;

   // ---------------------------------------------------------------
   // reset values (standard and low-power builds)
   // ---------------------------------------------------------------
   localparam logic [31:0] RESET_STD = 32'h0000383C;
   localparam logic [31:0] RESET_LP  = 32'h00003838;

   // ---------------------------------------------------------------
   // encodings
   // ---------------------------------------------------------------
   localparam logic [1:0] MODE_SYSTEM = 2'h0;
   localparam logic [1:0] MODE_ZERO   = 2'h2;
   localparam logic [1:0] MODE_VREF   = 2'h3;

   // control fields that software writes, high field first
   typedef struct packed {
      logic       arm_trigger;
      logic       ttl_sync;
      logic       low_freq_filter;
      logic       generator_a_clock_export;
      logic       flush_on_align;
      logic       free_running_sampling;
      logic [2:0] event_select;
      logic       initiator;
      logic       offset_binary;
      logic [1:0] range;
      logic [1:0] input_mode;
   } brd_ctrl_t;

   // completion and status reports from the surrounding logic
   typedef struct packed {
      logic irq_event;
      logic clocks_stable;
      logic init_done;
      logic cal_done;
      logic cal_fail;
      logic align_done;
   } brd_status_t;

endpackage

// ===== hw/command_bit.sv
// one self-clearing command bit: taken when idle, held until done
`timescale 1ns/10ps
module command_bit (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // request and completion
   input  wire logic req_i,
   input  wire logic done_i,
   // state
   output logic      busy_o,
   output logic      start_o
);

   // ---------------------------------------------------------------
   // busy level
   // ---------------------------------------------------------------
   // a request while busy is ignored so a running command is never cut short
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_o <= 1'b0;
      end else if (!busy_o && req_i) begin
         busy_o <= 1'b1;
      end else if (busy_o && done_i) begin
         busy_o <= 1'b0;
      end
   end

   // one-cycle start strobe in the cycle after the request is taken
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_o <= 1'b0;
      end else begin
         start_o <= !busy_o && req_i;
      end
   end

endmodule

// ===== hw/clock_export.sv
// external clock output source selection and divider
`timescale 1ns/10ps
module clock_export #(
   parameter int unsigned DIV_W = 8
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // selection
   input  wire logic             initiator_i,
   input  wire logic             gen_a_sel_i,
   input  wire logic             group0_ext_i,
   input  wire logic [DIV_W-1:0] group0_div_i,
   // clock ticks
   input  wire logic             rate_a_tick_i,
   input  wire logic             group0_tick_i,
   // export
   output logic                  clk_o
);

   logic [DIV_W-1:0] div_count;

   initial begin
      if (DIV_W < 1) begin
         $error("clock_export: DIV_W must be at least 1");
      end
   end

   // ---------------------------------------------------------------
   // divider on rate-A ticks
   // ---------------------------------------------------------------
   // divisor zero behaves as one, so the output never stalls
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_count <= '0;
      end else if (rate_a_tick_i) begin
         if (div_count + 1'b1 >= group0_div_i) begin
            div_count <= '0;
         end else begin
            div_count <= div_count + 1'b1;
         end
      end
   end

   // output source, only in the initiator role
   always_ff @(posedge clk_i) begin
      if (rst_i || !initiator_i) begin
         clk_o <= 1'b0;
      end else if (gen_a_sel_i) begin
         clk_o <= rate_a_tick_i;
      end else if (group0_ext_i) begin
         clk_o <= rate_a_tick_i && (div_count + 1'b1 >= group0_div_i);
      end else begin
         clk_o <= group0_tick_i;
      end
   end

endmodule

// ===== hw/board_control_register.sv
// board control register: control fields, commands and status flags
`timescale 1ns/10ps
module board_control_register #(
   parameter bit          LOW_POWER = 1'b0,
   parameter int unsigned COUNT_W   = 19,
   parameter int unsigned DIV_W     = 8
) (
   // clock and reset
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   // local register access, longwords only
   input  wire logic [brd_pkg::ADDR_W-1:0] bus_addr_i,
   input  wire logic                      bus_wr_i,
   input  wire logic                      bus_rd_i,
   input  wire logic [31:0]               bus_wdata_i,
   output logic      [31:0]               bus_rdata_o,
   output logic                           bus_ack_o,
   // reports from the surrounding logic
   input  wire brd_pkg::brd_status_t      status_i,
   input  wire logic [COUNT_W-1:0]        buf_count_i,
   input  wire logic [COUNT_W-1:0]        buf_threshold_i,
   // clock sources for export
   input  wire logic                      rate_a_tick_i,
   input  wire logic                      group0_tick_i,
   input  wire logic                      group0_ext_i,
   input  wire logic [DIV_W-1:0]          group0_div_i,
   // control fields
   output brd_pkg::brd_ctrl_t             ctrl_o,
   output logic                           sync_sampling_o,
   // command strobes
   output logic                           adc_sync_o,
   output logic                           ext_sync_o,
   output logic                           buffer_clear_o,
   output logic                           cal_start_o,
   output logic                           init_start_o,
   output logic                           param_change_o,
   // status level and exported clock
   output logic                           irq_req_o,
   output logic                           ext_clk_o
);

   // ---------------------------------------------------------------
   // reset value and elaboration checks
   // ---------------------------------------------------------------
   localparam logic [31:0] RESET_VALUE = LOW_POWER ? brd_pkg::RESET_LP
                                                   : brd_pkg::RESET_STD;

   initial begin
      if (COUNT_W < 1 || COUNT_W > 31) begin
         $error("board_control_register: COUNT_W out of range");
      end
      if (DIV_W < 1 || DIV_W > 31) begin
         $error("board_control_register: DIV_W out of range");
      end
   end

   // ---------------------------------------------------------------
   // field helpers
   // ---------------------------------------------------------------
   // unpack the writable control fields of a word
   function automatic brd_pkg::brd_ctrl_t ctrl_from_word(input logic [31:0] w);
      brd_pkg::brd_ctrl_t c;
      c.input_mode               = w[brd_pkg::POS_MODE +: 2];
      c.range                    = w[brd_pkg::POS_RANGE +: 2];
      c.offset_binary            = w[brd_pkg::POS_CODING];
      c.initiator                = w[brd_pkg::POS_INITIATOR];
      c.event_select             = w[brd_pkg::POS_EVSEL +: 3];
      c.free_running_sampling    = w[brd_pkg::POS_FREE];
      c.flush_on_align           = w[brd_pkg::POS_FLUSH];
      c.generator_a_clock_export = w[brd_pkg::POS_GENA];
      c.low_freq_filter          = w[brd_pkg::POS_LOWF];
      c.ttl_sync                 = w[brd_pkg::POS_TTL];
      c.arm_trigger              = w[brd_pkg::POS_TRIG];
      return c;
   endfunction

   // pack fields and flags into the readback word
   function automatic logic [31:0] word_of(input brd_pkg::brd_ctrl_t c,
                                           input logic [6:0] f);
      logic [31:0] w;
      w = '0;
      w[brd_pkg::POS_MODE +: 2]   = c.input_mode;
      w[brd_pkg::POS_RANGE +: 2]  = c.range;
      w[brd_pkg::POS_CODING]      = c.offset_binary;
      w[brd_pkg::POS_INITIATOR]   = c.initiator;
      w[brd_pkg::POS_ALIGN]       = f[0];
      w[brd_pkg::POS_CAL]         = f[1];
      w[brd_pkg::POS_EVSEL +: 3]  = c.event_select;
      w[brd_pkg::POS_IRQ]         = f[2];
      w[brd_pkg::POS_CALOK]       = f[3];
      w[brd_pkg::POS_SETTLED]     = f[4];
      w[brd_pkg::POS_FILL]        = f[5];
      w[brd_pkg::POS_INIT]        = f[6];
      w[brd_pkg::POS_FREE]        = c.free_running_sampling;
      w[brd_pkg::POS_FLUSH]       = c.flush_on_align;
      w[brd_pkg::POS_GENA]        = c.generator_a_clock_export;
      w[brd_pkg::POS_LOWF]        = c.low_freq_filter;
      w[brd_pkg::POS_TTL]         = c.ttl_sync;
      w[brd_pkg::POS_TRIG]        = c.arm_trigger;
      return w;
   endfunction

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   brd_pkg::brd_ctrl_t ctrl;
   brd_pkg::brd_ctrl_t next_ctrl;
   logic               hit;
   logic               wr_hit;
   logic               align_busy;
   logic               align_start;
   logic               cal_busy;
   logic               init_busy;
   logic               flush_mode;
   logic               irq_flag;
   logic               cal_ok;
   logic               settled;
   logic               settle_pending;
   logic               fill;
   logic               params_differ;

   // only the aligned longword at offset zero is decoded
   assign hit    = bus_addr_i == brd_pkg::BOARD_CONTROL_OFFSET;
   assign wr_hit = bus_wr_i && hit;
   assign next_ctrl = ctrl_from_word(bus_wdata_i);

   // a write that moves a settling-critical field
   assign params_differ = wr_hit &&
                          (next_ctrl.input_mode != ctrl.input_mode ||
                           next_ctrl.range != ctrl.range ||
                           next_ctrl.low_freq_filter != ctrl.low_freq_filter ||
                           next_ctrl.free_running_sampling
                              != ctrl.free_running_sampling);

   // ---------------------------------------------------------------
   // control fields
   // ---------------------------------------------------------------
   // initialization reloads every control field default one cycle after its write
   always_ff @(posedge clk_i) begin
      if (rst_i || init_start_o) begin
         ctrl <= ctrl_from_word(RESET_VALUE);
      end else if (wr_hit) begin
         ctrl <= next_ctrl;
      end
   end

   assign ctrl_o          = ctrl;
   assign sync_sampling_o = !ctrl.free_running_sampling;

   // ---------------------------------------------------------------
   // self-clearing commands
   // ---------------------------------------------------------------
   // writing a zero to a command bit is simply no request
   command_bit u_align (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .req_i   (wr_hit && bus_wdata_i[brd_pkg::POS_ALIGN]),
      .done_i  (status_i.align_done),
      .busy_o  (align_busy),
      .start_o (align_start)
   );

   command_bit u_cal (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .req_i   (wr_hit && bus_wdata_i[brd_pkg::POS_CAL]),
      .done_i  (status_i.cal_done),
      .busy_o  (cal_busy),
      .start_o (cal_start_o)
   );

   command_bit u_init (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .req_i   (wr_hit && bus_wdata_i[brd_pkg::POS_INIT]),
      .done_i  (status_i.init_done),
      .busy_o  (init_busy),
      .start_o (init_start_o)
   );

   // flush context is caught with the request, not read at the strobe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flush_mode <= 1'b0;
      end else if (wr_hit && bus_wdata_i[brd_pkg::POS_ALIGN] && !align_busy) begin
         flush_mode <= next_ctrl.flush_on_align;
      end
   end

   // strobes are ands of flops, one cycle wide
   assign buffer_clear_o = align_start && flush_mode;
   assign adc_sync_o     = align_start && !flush_mode;
   assign ext_sync_o     = adc_sync_o && ctrl.initiator;

   // ---------------------------------------------------------------
   // interrupt pending flag
   // ---------------------------------------------------------------
   // a request in the cycle of the host clear wins over the clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_flag <= RESET_VALUE[brd_pkg::POS_IRQ];
      end else if (status_i.irq_event) begin
         irq_flag <= 1'b1;
      end else if (wr_hit && !bus_wdata_i[brd_pkg::POS_IRQ]) begin
         irq_flag <= 1'b0;
      end
   end

   assign irq_req_o = irq_flag;

   // ---------------------------------------------------------------
   // calibration ok flag
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cal_ok <= RESET_VALUE[brd_pkg::POS_CALOK];
      end else if (cal_start_o) begin
         cal_ok <= 1'b1;
      end else if (cal_busy && status_i.cal_done && status_i.cal_fail) begin
         cal_ok <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // channels settled flag
   // ---------------------------------------------------------------
   // pending holds the flag low until the clock logic has dropped
   // its stable report, so a slow reaction cannot leave a stale high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         settle_pending <= 1'b0;
      end else if (param_change_o) begin
         settle_pending <= 1'b1;
      end else if (!status_i.clocks_stable) begin
         settle_pending <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         param_change_o <= 1'b0;
      end else begin
         param_change_o <= params_differ || init_start_o || align_start;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         settled <= RESET_VALUE[brd_pkg::POS_SETTLED];
      end else if (params_differ || param_change_o || settle_pending) begin
         settled <= 1'b0;
      end else begin
         settled <= status_i.clocks_stable;
      end
   end

   // ---------------------------------------------------------------
   // buffer fill level flag
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fill <= RESET_VALUE[brd_pkg::POS_FILL];
      end else begin
         fill <= buf_count_i > buf_threshold_i;
      end
   end

   // ---------------------------------------------------------------
   // readback
   // ---------------------------------------------------------------
   // unmapped reads answer zero; every access is acknowledged
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_rdata_o <= '0;
      end else if (bus_rd_i && hit) begin
         bus_rdata_o <= word_of(ctrl, {init_busy, fill, settled, cal_ok,
                                       irq_flag, cal_busy, align_busy});
      end else if (bus_rd_i) begin
         bus_rdata_o <= '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_ack_o <= 1'b0;
      end else begin
         bus_ack_o <= bus_rd_i || bus_wr_i;
      end
   end

   // ---------------------------------------------------------------
   // external clock export
   // ---------------------------------------------------------------
   clock_export #(
      .DIV_W (DIV_W)
   ) u_clk_export (
      .clk_i         (clk_i),
      .rst_i         (rst_i),
      .initiator_i   (ctrl.initiator),
      .gen_a_sel_i   (ctrl.generator_a_clock_export),
      .group0_ext_i  (group0_ext_i),
      .group0_div_i  (group0_div_i),
      .rate_a_tick_i (rate_a_tick_i),
      .group0_tick_i (group0_tick_i),
      .clk_o         (ext_clk_o)
   );

endmodule

// ===== verif/bcr_assertions.sv
// concurrent checks on the board control register ports
`timescale 1ns/10ps
module brd_assertions (
   // clock, reset and bus
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic [7:0]           bus_addr_i,
   input  wire logic                 bus_wr_i,
   input  wire logic                 bus_rd_i,
   input  wire logic [31:0]          bus_wdata_i,
   input  wire logic [31:0]          bus_rdata_o,
   input  wire logic                 bus_ack_o,
   // reports and outputs
   input  wire brd_pkg::brd_status_t status_i,
   input  wire brd_pkg::brd_ctrl_t   ctrl_o,
   input  wire logic                 sync_sampling_o,
   input  wire logic                 adc_sync_o,
   input  wire logic                 ext_sync_o,
   input  wire logic                 buffer_clear_o,
   input  wire logic                 init_start_o,
   input  wire logic                 irq_req_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ---------------------------------------------------------------
   // bus answers, command strobes, control fields and pending flag
   // ---------------------------------------------------------------
   sequence s_init_taken;
      bus_wr_i && bus_wdata_i[15] ##1 init_start_o;
   endsequence
   chk_ack_one_cycle: assert property ((bus_wr_i || bus_rd_i) |=> bus_ack_o)
      else $error("ack missing after strobe");
   chk_reserved_read_zero: assert property (bus_rd_i |=> bus_rdata_o[31:22] == 10'h000)
      else $error("reserved bits read nonzero");
   chk_unmapped_read: assert property (bus_rd_i && bus_addr_i != 8'h00 |=> bus_rdata_o == 32'h0)
      else $error("unmapped read nonzero");
   chk_sync_cause: assert property (adc_sync_o |-> $past(bus_wr_i && bus_wdata_i[6] && !bus_wdata_i[17]))
      else $error("sync strobe without align write");
   chk_flush_cause: assert property (buffer_clear_o |-> !adc_sync_o && $past(bus_wr_i && bus_wdata_i[17]))
      else $error("buffer clear without flush align");
   chk_ext_sync_local: assert property (ext_sync_o |-> adc_sync_o)
      else $error("external sync without local sync");
   chk_init_defaults: assert property (s_init_taken |=> ctrl_o == 15'h003C)
      else $error("fields not back to defaults");
   chk_irq_sets_flag: assert property (status_i.irq_event |=> irq_req_o)
      else $error("pending flag not set");
   chk_free_run_sync: assert property (sync_sampling_o != ctrl_o.free_running_sampling)
      else $error("sync sampling level wrong");
endmodule

// ===== verif/done_responder.sv
// completion model for the converter logic around the register
`timescale 1ns/10ps
module done_responder #(
   parameter int unsigned LAT = 6
) (
   // clock and reset
   input  wire logic           clk_i,
   input  wire logic           rst_i,
   // command strobes from the register
   input  wire logic           align_i,
   input  wire logic           cal_i,
   input  wire logic           init_i,
   // scenario controls
   input  wire logic           cal_fail_i,
   input  wire logic           irq_i,
   input  wire logic           stable_i,
   // reports back
   output brd_pkg::brd_status_t status_o
);
   logic [7:0] a_cnt;
   logic [7:0] c_cnt;
   logic [7:0] n_cnt;
   // ---------------------------------------------------------------
   // one countdown per operation; a slow answer keeps commands busy
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      a_cnt <= rst_i ? 8'h00 : align_i ? 8'(LAT) : (a_cnt != 8'h00) ? a_cnt - 8'h01 : a_cnt;
      c_cnt <= rst_i ? 8'h00 : cal_i ? 8'(LAT) : (c_cnt != 8'h00) ? c_cnt - 8'h01 : c_cnt;
      n_cnt <= rst_i ? 8'h00 : init_i ? 8'(LAT) : (n_cnt != 8'h00) ? n_cnt - 8'h01 : n_cnt;
   end
   // fail is a level, only meaningful together with the done pulse
   assign status_o = '{irq_event: irq_i, clocks_stable: stable_i, init_done: n_cnt == 8'h01,
                       cal_done: c_cnt == 8'h01, cal_fail: cal_fail_i,
                       align_done: a_cnt == 8'h01};
endmodule

// ===== verif/tb.sv
// self-checking bench for the board control register
`timescale 1ns/10ps
module tb;
   logic                 clk_i, rst_i, bus_wr_i, bus_rd_i, bus_ack_o, fail, irq, stable;
   logic                 tick_a, g0_ext;
   logic [7:0]           bus_addr_i;
   logic [31:0]          bus_wdata_i, bus_rdata_o, rd_word;
   logic [18:0]          count, thr;
   logic                 adc_sync_o, ext_sync_o, buffer_clear_o, cal_start_o, init_start_o;
   logic                 param_change_o, irq_req_o, ext_clk_o, sync_sampling_o;
   brd_pkg::brd_status_t status;
   brd_pkg::brd_ctrl_t   ctrl;
   int                   bad_count = 0;
   int                   n_compared = 0;
   // group tick is the inverse of the rate-A tick
   board_control_register i_dut (.clk_i(clk_i), .rst_i(rst_i), .bus_addr_i(bus_addr_i),
      .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_wdata_i(bus_wdata_i),
      .bus_rdata_o(bus_rdata_o), .bus_ack_o(bus_ack_o), .status_i(status), .buf_count_i(count),
      .buf_threshold_i(thr), .rate_a_tick_i(tick_a), .group0_tick_i(!tick_a),
      .group0_ext_i(g0_ext), .group0_div_i(8'h03), .ctrl_o(ctrl), .sync_sampling_o(sync_sampling_o),
      .adc_sync_o(adc_sync_o), .ext_sync_o(ext_sync_o), .buffer_clear_o(buffer_clear_o),
      .cal_start_o(cal_start_o), .init_start_o(init_start_o), .param_change_o(param_change_o),
      .irq_req_o(irq_req_o), .ext_clk_o(ext_clk_o));
   done_responder i_far (.clk_i(clk_i), .rst_i(rst_i), .align_i(adc_sync_o | buffer_clear_o),
      .cal_i(cal_start_o), .init_i(init_start_o), .cal_fail_i(fail), .irq_i(irq),
      .stable_i(stable), .status_o(status));
   // ---------------------------------------------------------------
   // compare, bus and closing tasks
   // ---------------------------------------------------------------
   task automatic word_is(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic bit_is(input logic got, input logic exp, input string m);
      word_is({31'h0, got}, {31'h0, exp}, m);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge clk_i);
      bus_addr_i = a;
      bus_wdata_i = d;
      bus_wr_i = 1'b1;
      @(negedge clk_i);
      bus_wr_i = 1'b0;
      bit_is(bus_ack_o, 1'b1, "write ack");
   endtask
   task automatic rd(input logic [7:0] a);
      @(negedge clk_i);
      bus_addr_i = a;
      bus_rd_i = 1'b1;
      @(negedge clk_i);
      bus_rd_i = 1'b0;
      rd_word = bus_rdata_o;
      bit_is(bus_ack_o, 1'b1, "read ack");
   endtask
   // bounded poll until a command bit drops
   task automatic wait_clear(input int b);
      rd(8'h00);
      for (int k = 0; k < 20 && rd_word[b] !== 1'b0; k++) begin
         rd(8'h00);
      end
      bit_is(rd_word[b], 1'b0, "command bit cleared");
   endtask
   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_fields();
      rd(8'h00);
      word_is(rd_word, brd_pkg::RESET_STD, "reset word");
      word_is({17'h0, ctrl}, 32'h0000_003C, "reset fields");
      wr(8'h00, 32'hFFFF_7F3F);
      bit_is(param_change_o, 1'b1, "parameter change");
      rd(8'h00);
      word_is(rd_word & 32'hFFFF_DFFF, 32'h003F_1F3F, "all fields set");
      word_is({17'h0, ctrl}, 32'h0000_7FFF, "field outputs");
      bit_is(sync_sampling_o, 1'b0, "free running");
      wr(8'h00, 32'h0);
      rd(8'h00);
      word_is(rd_word & 32'hFFFF_DFFF, 32'h0000_1000, "all cleared");
      bit_is(sync_sampling_o, 1'b1, "sync sampling");
   endtask
   task automatic t_settle_fill();
      stable = 1'b0;
      rd(8'h00);
      bit_is(rd_word[13], 1'b0, "settling");
      stable = 1'b1;
      rd(8'h00);
      word_is(rd_word, 32'h0000_3000, "settled");
      wr(8'h04, 32'h0000_0030);
      rd(8'h04);
      word_is(rd_word, 32'h0, "unmapped read");
      count = 19'h6;
      rd(8'h00);
      word_is(rd_word, 32'h0000_7000, "above threshold");
      count = 19'h5;
      rd(8'h00);
      bit_is(rd_word[14], 1'b0, "at threshold");
   endtask
   task automatic t_irq();
      @(negedge clk_i);
      irq = 1'b1;
      @(negedge clk_i);
      irq = 1'b0;
      bit_is(irq_req_o, 1'b1, "pending set");
      wr(8'h00, 32'h0000_0800);
      bit_is(irq_req_o, 1'b1, "write one keeps");
      wr(8'h00, 32'h0);
      bit_is(irq_req_o, 1'b0, "write zero clears");
   endtask
   task automatic t_align();
      wr(8'h00, 32'h0000_0020);
      wr(8'h00, 32'h0000_0060);
      bit_is(adc_sync_o & ext_sync_o & !buffer_clear_o, 1'b1, "initiator sync");
      wr(8'h00, 32'h0000_0020);
      rd(8'h00);
      bit_is(rd_word[6], 1'b1, "zero write keeps busy");
      wait_clear(6);
      wr(8'h00, 32'h0002_0060);
      bit_is(buffer_clear_o & !adc_sync_o, 1'b1, "flush instead of sync");
      wait_clear(6);
      wr(8'h00, 32'h0);
      wr(8'h00, 32'h0000_0040);
      bit_is(adc_sync_o & !ext_sync_o, 1'b1, "target sync local only");
      wait_clear(6);
   endtask
   task automatic t_cal_init();
      fail = 1'b1;
      wr(8'h00, 32'h0000_0080);
      bit_is(cal_start_o, 1'b1, "cal start");
      rd(8'h00);
      bit_is(rd_word[12] & rd_word[7], 1'b1, "cal running ok high");
      wait_clear(7);
      bit_is(rd_word[12], 1'b0, "cal failed");
      fail = 1'b0;
      wr(8'h00, 32'h0000_0080);
      wait_clear(7);
      bit_is(rd_word[12], 1'b1, "cal passed");
      wr(8'h00, 32'h003F_073F);
      wr(8'h00, 32'h0000_8000);
      bit_is(init_start_o, 1'b1, "init start");
      wait_clear(15);
      word_is({17'h0, ctrl}, 32'h0000_003C, "init defaults");
   endtask
   task automatic tick_is(input logic exp, input string m);
      @(negedge clk_i);
      tick_a = 1'b1;
      @(negedge clk_i);
      tick_a = 1'b0;
      bit_is(ext_clk_o, exp, m);
   endtask
   task automatic t_export();
      g0_ext = 1'b1;
      tick_is(1'b0, "div 1");
      tick_is(1'b0, "div 2");
      tick_is(1'b1, "div 3");
      g0_ext = 1'b0;
      tick_is(1'b0, "group tick");
      wr(8'h00, 32'h0004_0020);
      tick_is(1'b1, "rate A tick");
      wr(8'h00, 32'h0004_0000);
      tick_is(1'b0, "target");
   endtask
   // clock, watchdog and main sequence
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   initial begin
      #(100 * 4000);
      bad_count++;
      conclude();
   end
   initial begin
      {bus_wr_i, bus_rd_i, fail, irq, tick_a, g0_ext, bus_addr_i, bus_wdata_i, count} = '0;
      {rst_i, stable} = 2'h3;
      thr = 19'h5;
      repeat (6) @(negedge clk_i);
      rst_i = 1'b0;
      t_fields();
      t_settle_fill();
      t_irq();
      t_align();
      t_cal_init();
      t_export();
      conclude();
   end
endmodule
bind board_control_register brd_assertions i_chk (.*);
